// ---- design/bright_map.svh ----
// Constants for the one-wire brightness command decoder
`ifndef BRIGHT_MAP_SVH
`define BRIGHT_MAP_SVH

`define CLK_MHZ        50
`define FRAME_BITS     24
`define FRAME_CNT_W    5
`define ADDR_MSB_POS   23
`define ADDR_LSB_POS   16
`define DEV_ADDR       8'h8f
`define ACK_FLAG_POS   10
`define BRIGHT_MSB_POS 8
`define BRIGHT_LSB_POS 0
`define BRIGHT_RST     9'h1ff
`define CNT_W          18
`define T_EOS_US       2
`define T_EOS_CYC      (`T_EOS_US * `CLK_MHZ)
`define T_ACK_US       512
`define T_ACK_CYC      (`T_ACK_US * `CLK_MHZ)
`define T_VALACK_US    2
`define T_VALACK_CYC   (`T_VALACK_US * `CLK_MHZ)
`define T_IDLE_US      1000
`define T_IDLE_CYC     (`T_IDLE_US * `CLK_MHZ)

`endif

// ---- design/bright_pkg.sv ----
// Types for the one-wire brightness command decoder
`include "bright_map.svh"

package bright_pkg;

	typedef enum logic [1:0] {
		ST_RX,
		ST_VALACK,
		ST_ACK
	} dec_state_t;

	typedef struct packed {
		dec_state_t                state;
		logic [`FRAME_BITS-1:0]    shift;
		logic [`FRAME_CNT_W-1:0]   cnt;
		logic                      bad;
		logic [`CNT_W-1:0]         wait_cnt;
		logic [8:0]                bright;
		logic                      upd;
		logic                      clr;
		logic                      pull;
	} dec_regs_t;

	typedef struct packed {
		logic                      line_d;
		logic                      seen;
		logic [`CNT_W-1:0]         low_cnt;
		logic [`CNT_W-1:0]         high_cnt;
		logic                      bit_stb;
		logic                      bit_val;
		logic                      bit_err;
		logic                      eos;
		logic                      tmo;
	} tmr_regs_t;

endpackage

// ---- design/bit_if.sv ----
// Carrier between the bit timer and the frame decoder
`timescale 1ns/10ps
`default_nettype none

interface bit_if;
	logic clr;
	logic bit_stb;
	logic bit_val;
	logic bit_err;
	logic eos;
	logic tmo;

	modport timer (
		input  clr,
		output bit_stb,
		output bit_val,
		output bit_err,
		output eos,
		output tmo
	);

	modport dec (
		output clr,
		input  bit_stb,
		input  bit_val,
		input  bit_err,
		input  eos,
		input  tmo
	);
endinterface

`default_nettype wire

// ---- design/bit_timer.sv ----
// Bit timer: measures low and high time between falling edges
`timescale 1ns/10ps
`default_nettype none
`include "bright_map.svh"

module bit_timer #(
	parameter int TIMEOUT_CYC = `T_IDLE_CYC
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Line level
	input  wire logic  line_in,
	// Decoder side
	bit_if.timer       bi
);
	import bright_pkg::*;

	tmr_regs_t r_ff;
	tmr_regs_t nxt_r;

	logic                   fall;
	logic [`CNT_W:0]        high_x2;
	logic [`CNT_W:0]        low_x2;

	always_comb begin
		nxt_r = r_ff;
		fall = r_ff.line_d & ~line_in;
		high_x2 = {r_ff.high_cnt, 1'b0};
		low_x2 = {r_ff.low_cnt, 1'b0};
		nxt_r.line_d = line_in;
		nxt_r.bit_stb = 1'b0;
		nxt_r.eos = 1'b0;
		nxt_r.tmo = 1'b0;
		if (bi.clr) begin
			nxt_r.seen = 1'b0;
			nxt_r.low_cnt = '0;
			nxt_r.high_cnt = '0;
		end else if (fall) begin
			// A bit closes at the falling edge that opens the next one
			if (r_ff.seen) begin
				nxt_r.bit_stb = 1'b1;
				nxt_r.bit_val = {1'b0, r_ff.high_cnt} >= low_x2;
				nxt_r.bit_err = ({1'b0, r_ff.high_cnt} < low_x2) && ({1'b0, r_ff.low_cnt} < high_x2);
			end
			nxt_r.seen = 1'b1;
			// The cycle of the fall is already the first low cycle; starting at zero biases zeros to ambiguous
			nxt_r.low_cnt = `CNT_W'(1);
			nxt_r.high_cnt = '0;
		end else if (line_in) begin
			if (r_ff.high_cnt != {`CNT_W{1'b1}})
				nxt_r.high_cnt = r_ff.high_cnt + `CNT_W'(1);
			if (r_ff.seen && r_ff.high_cnt == `CNT_W'(TIMEOUT_CYC - 1))
				nxt_r.tmo = 1'b1;
		end else begin
			if (r_ff.low_cnt != {`CNT_W{1'b1}})
				nxt_r.low_cnt = r_ff.low_cnt + `CNT_W'(1);
			if (r_ff.seen && r_ff.low_cnt == `CNT_W'(`T_EOS_CYC - 1))
				nxt_r.eos = 1'b1;
			if (r_ff.seen && r_ff.low_cnt == `CNT_W'(TIMEOUT_CYC - 1))
				nxt_r.tmo = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '{line_d: 1'b1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign bi.bit_stb = r_ff.bit_stb;
	assign bi.bit_val = r_ff.bit_val;
	assign bi.bit_err = r_ff.bit_err;
	assign bi.eos     = r_ff.eos;
	assign bi.tmo     = r_ff.tmo;
endmodule // bit_timer

`default_nettype wire

// ---- design/bright_cmd_decoder.sv ----
// One-wire brightness command decoder, device end
`timescale 1ns/10ps
`default_nettype none
`include "bright_map.svh"

module bright_cmd_decoder #(
	parameter int ACK_CYC     = `T_ACK_CYC,
	parameter int VALACK_CYC  = `T_VALACK_CYC,
	parameter int TIMEOUT_CYC = `T_IDLE_CYC
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	// One-wire line, open drain
	input  wire logic        LINE_IN,
	output logic             LINE_OUT,
	output logic             LINE_OE_N,
	// Brightness result
	output logic [8:0]       BRIGHTNESS,
	output logic             BRIGHT_UPD,
	output logic             ACK_BUSY
);
	import bright_pkg::*;

	bit_if bi ();

	dec_regs_t r_ff;
	dec_regs_t nxt_r;

	logic [7:0] addr_byte;
	logic       frame_ok;

	// ------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------
	bit_timer #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_timer (
		.clk     (REF_CLK),
		.rst_n   (RSTN),
		.line_in (LINE_IN),
		.bi      (bi)
	);

	// Timer is held cleared through the acknowledge so our own pull-down is not decoded
	assign bi.clr = r_ff.clr | (r_ff.state != ST_RX);

	// ------------------------------------------------------------
	// Frame assembly and acknowledge
	// ------------------------------------------------------------
	assign addr_byte = r_ff.shift[`ADDR_MSB_POS:`ADDR_LSB_POS];
	assign frame_ok  = !r_ff.bad && r_ff.cnt == `FRAME_CNT_W'(`FRAME_BITS);

	always_comb begin
		nxt_r = r_ff;
		nxt_r.upd = 1'b0;
		nxt_r.clr = 1'b0;
		case (r_ff.state)
			ST_RX: begin
				if (bi.tmo) begin
					// Stalled line abandons a partial frame
					nxt_r.cnt = '0;
					nxt_r.bad = 1'b0;
					nxt_r.clr = 1'b1;
				end else if (bi.bit_stb) begin
					if (r_ff.cnt == `FRAME_CNT_W'(`FRAME_BITS)) begin
						nxt_r.bad = 1'b1;
					end else begin
						// First bit in ends at bit 0 after all shifts
						nxt_r.shift = {bi.bit_val, r_ff.shift[`FRAME_BITS-1:1]};
						nxt_r.cnt = r_ff.cnt + `FRAME_CNT_W'(1);
						if (bi.bit_err)
							nxt_r.bad = 1'b1;
					end
				end else if (bi.eos && r_ff.cnt == `FRAME_CNT_W'(`FRAME_BITS)) begin
					// End of stream closes the frame; filler bits 15..11 and 9 unused
					nxt_r.cnt = '0;
					nxt_r.bad = 1'b0;
					nxt_r.clr = 1'b1;
					if (frame_ok && addr_byte == `DEV_ADDR) begin
						nxt_r.bright = r_ff.shift[`BRIGHT_MSB_POS:`BRIGHT_LSB_POS];
						nxt_r.upd = 1'b1;
						if (r_ff.shift[`ACK_FLAG_POS]) begin
							nxt_r.state = ST_VALACK;
							nxt_r.wait_cnt = '0;
						end
					end
				end
			end
			ST_VALACK: begin
				// Master still holds the line low here
				nxt_r.wait_cnt = r_ff.wait_cnt + `CNT_W'(1);
				if (r_ff.wait_cnt == `CNT_W'(VALACK_CYC - 1)) begin
					nxt_r.state = ST_ACK;
					nxt_r.wait_cnt = '0;
				end
			end
			ST_ACK: begin
				nxt_r.wait_cnt = r_ff.wait_cnt + `CNT_W'(1);
				if (r_ff.wait_cnt == `CNT_W'(ACK_CYC - 1)) begin
					nxt_r.state = ST_RX;
					nxt_r.wait_cnt = '0;
					nxt_r.clr = 1'b1;
				end
			end
			default: begin
				nxt_r.state = ST_RX;
				nxt_r.clr = 1'b1;
			end
		endcase
		nxt_r.pull = (nxt_r.state == ST_ACK);
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			r_ff <= '{state: ST_RX, bright: `BRIGHT_RST, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign LINE_OUT   = 1'b0;
	assign LINE_OE_N  = ~r_ff.pull;
	assign BRIGHTNESS = r_ff.bright;
	assign BRIGHT_UPD = r_ff.upd;
	assign ACK_BUSY   = r_ff.state != ST_RX;
endmodule // bright_cmd_decoder

`default_nettype wire

// ---- tb/bright_cmd_decoder_assertions.sv ----
// Port checks for the brightness command decoder
`timescale 1ns/10ps
`default_nettype none

module bright_cmd_decoder_assertions #(
	parameter int ACK_CYC    = 64,
	parameter int VALACK_CYC = 4
) (
	input wire logic       REF_CLK,
	input wire logic       RSTN,
	input wire logic       LINE_IN,
	input wire logic       LINE_OUT,
	input wire logic       LINE_OE_N,
	input wire logic [8:0] BRIGHTNESS,
	input wire logic       BRIGHT_UPD,
	input wire logic       ACK_BUSY
);
	localparam int VA_LO = VALACK_CYC - 1;
	localparam int VA_HI = VALACK_CYC + 1;
	logic [15:0] low_ff;

	// Length of the current pull
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			low_ff <= 16'h0;
		else if (LINE_OE_N)
			low_ff <= 16'h0;
		else
			low_ff <= low_ff + 16'h1;
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_commit_ack;
		BRIGHT_UPD && ACK_BUSY;
	endsequence
	sequence s_pull_start;
		##[VA_LO:VA_HI] $fell(LINE_OE_N);
	endsequence

	AST_DRIVE_ZERO: assert property (LINE_OUT == 1'b0) else $error("line data not zero");
	AST_ACK_DELAY: assert property (s_commit_ack |-> s_pull_start) else $error("ack not started");
	AST_NO_FLAG: assert property (BRIGHT_UPD && !ACK_BUSY |-> LINE_OE_N [*8]) else $error("pull without flag");
	AST_PULL_LEN: assert property ($rose(LINE_OE_N) |-> low_ff == ACK_CYC) else $error("pull length");
	AST_PULL_BUSY: assert property (!LINE_OE_N |-> ACK_BUSY) else $error("pull outside busy");
	AST_UPD_PULSE: assert property (BRIGHT_UPD |=> !BRIGHT_UPD) else $error("update too long");
	AST_CODE_HOLD: assert property ($changed(BRIGHTNESS) |-> BRIGHT_UPD) else $error("code moved");
	AST_UPD_EOS: assert property (BRIGHT_UPD |-> !LINE_IN && $past(LINE_IN, 50) == 1'b0) else $error("early commit");
endmodule // bright_cmd_decoder_assertions

bind bright_cmd_decoder bright_cmd_decoder_assertions #(.ACK_CYC(ACK_CYC), .VALACK_CYC(VALACK_CYC)) u_chk (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N),
	.BRIGHTNESS(BRIGHTNESS), .BRIGHT_UPD(BRIGHT_UPD), .ACK_BUSY(ACK_BUSY));

`default_nettype wire

// ---- tb/host_master.sv ----
// Open-drain host model sending command frames
`timescale 1ns/10ps
`default_nettype none

module host_master (
	input  wire logic clk,
	output var logic  drv
);
	initial drv = 1'b1;

	// Level v for n clock edges; high means released
	task automatic seg(input logic v, input int n);
		@(posedge clk);
		#1 drv = v;
		repeat (n - 1) @(posedge clk);
	endtask

	// Nb bits go out, the frame repeating past bit 23; tail is the closing low time
	task automatic send(input logic [23:0] f, input int bad, input int nb, input int tail);
		seg(1'b1, 110);
		for (int i = 0; i < nb; i++) begin
			if (i == bad) begin
				seg(1'b0, 3);
				seg(1'b1, 3);
			end else if (f[i % 24]) begin
				seg(1'b0, 2);
				seg(1'b1, 4);
			end else begin
				seg(1'b0, 4);
				seg(1'b1, 2);
			end
		end
		// Kept low through the ack delay, then released; a short tail leaves a cut frame
		seg(1'b0, tail);
		seg(1'b1, 2);
	endtask
endmodule // host_master

`default_nettype wire

// ---- tb/one_wire_brightness_command_decoder_tb.sv ----
// Testbench for the brightness command decoder
`timescale 1ns/10ps
`default_nettype none

module one_wire_brightness_command_decoder_tb;
	typedef struct {
		logic [23:0] f;
		int          bad;
		logic [8:0]  b;
		int          upd;
		int          pull;
	} row_t;

	logic       clk;
	logic       rst_n;
	logic       drv;
	logic       line;
	logic       line_out;
	logic       oe_n;
	logic [8:0] bright;
	logic       upd;
	logic       busy;
	int         n_mismatch = 0;
	int         checked = 0;
	int         n_upd;
	int         n_pull;
	int         k;
	row_t       rows [8] = '{
		'{24'h8f00a5, 99, 9'h0a5, 1, 0}, '{24'h8f055a, 99, 9'h15a, 1, 64},
		'{24'h0f0123, 99, 9'h15a, 0, 0}, '{24'h8e0401, 99, 9'h15a, 0, 0},
		'{24'h8ffa33, 99, 9'h033, 1, 0}, '{24'h8f05ff, 5, 9'h033, 0, 0},
		'{24'h8f05ff, 99, 9'h1ff, 1, 64}, '{24'h8f0000, 99, 9'h000, 1, 0}};

	// Pull-up: low when either end pulls
	assign line = drv & (oe_n | line_out);

	host_master i_host_master (.clk(clk), .drv(drv));

	bright_cmd_decoder #(.ACK_CYC(64), .VALACK_CYC(4), .TIMEOUT_CYC(2000)) i_bright_cmd_decoder (
		.REF_CLK(clk), .RSTN(rst_n), .LINE_IN(line), .LINE_OUT(line_out), .LINE_OE_N(oe_n),
		.BRIGHTNESS(bright), .BRIGHT_UPD(upd), .ACK_BUSY(busy));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (upd === 1'b1)
			n_upd++;
		if (oe_n === 1'b0)
			n_pull++;
	end

	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic summarize;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One frame, then the code, update count and pull length it should leave
	task automatic run(input logic [23:0] f, input int bad, input int nb, input int tail,
			input logic [8:0] b, input int u, input int p);
		n_upd = 0;
		n_pull = 0;
		i_host_master.send(f, bad, nb, tail);
		for (k = 0; k < 200 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		chk(k < 200, "busy stuck");
		if (k >= 200)
			summarize();
		chk(bright === b, "code");
		chk(n_upd == u, "update count");
		chk(n_pull == p, "ack length");
	endtask

	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(bright === 9'h1ff && oe_n === 1'b1 && line_out === 1'b0 && busy === 1'b0, "reset");
		foreach (rows[i])
			run(rows[i].f, rows[i].bad, 24, 110, rows[i].b, rows[i].upd, rows[i].pull);
		// A 25th bit spoils the frame
		run(24'h8f0011, 99, 25, 110, 9'h000, 0, 0);
		// Cut frame, then idle past the timeout so the next frame starts clean
		run(24'h8f0123, 99, 10, 30, 9'h000, 0, 0);
		repeat (2100) @(posedge clk);
		run(24'h8f0077, 99, 24, 110, 9'h077, 1, 0);
		// Second reset in mid-run restores the default code
		#1 rst_n = 1'b0;
		repeat (8) @(posedge clk);
		chk(bright === 9'h1ff && oe_n === 1'b1 && upd === 1'b0, "mid reset");
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(bright === 9'h1ff && oe_n === 1'b1 && busy === 1'b0 && upd === 1'b0, "after release");
		run(24'h8f0445, 99, 24, 110, 9'h045, 1, 64);
		summarize();
	end
endmodule // one_wire_brightness_command_decoder_tb

`default_nettype wire
